/* common/term_sel_pkg.sv */
package term_sel_pkg;

    // --------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_CODE0  = 8'h00;
    localparam logic [7:0] OFS_FCMODE = 8'h1C;
    localparam logic [7:0] OFS_REMOTE = 8'h20;
    localparam logic [7:0] OFS_ESTEP  = 8'h24;
    localparam logic [7:0] OFS_MTHR   = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;

    // --------------------------------------------------------------
    // field layout and reset values
    // --------------------------------------------------------------
    localparam int         CODE_W       = 10;
    localparam int         FCMODE_POS   = 0;
    localparam logic [9:0] RST_CODE_RUN = 10'h000;
    localparam logic [9:0] RST_CODE_ALM = 10'h063;
    localparam logic [9:0] RST_CODE_OFF = 10'h3E7;
    localparam int         RST_TERM_ALM = 5;
    localparam logic [0:0] RST_FCMODE   = 1'h0;

    // --------------------------------------------------------------
    // function codes (positive logic; negative adds the offset)
    // --------------------------------------------------------------
    localparam logic [9:0] CODE_NEG_OFS = 10'h064;
    localparam logic [9:0] CODE_NEG_END = 10'h0C7;
    localparam logic [9:0] CODE_RUN     = 10'h000;
    localparam logic [9:0] CODE_READY   = 10'h00B;
    localparam logic [9:0] CODE_START_CMD_RUNNING_OUT    = 10'h02D;
    localparam logic [9:0] CODE_ENERGY  = 10'h04F;
    localparam logic [9:0] CODE_NET     = 10'h052;
    localparam logic [9:0] CODE_DCFEED  = 10'h055;
    localparam logic [9:0] CODE_LIFE    = 10'h05A;
    localparam logic [9:0] CODE_PWROFF  = 10'h05B;
    localparam logic [9:0] CODE_SAVTOG  = 10'h05C;
    localparam logic [9:0] CODE_AVGCUR  = 10'h05D;
    localparam logic [9:0] CODE_SECONDARY_FAULT_OUT    = 10'h05E;
    localparam logic [9:0] CODE_MAINT   = 10'h05F;
    localparam logic [9:0] CODE_REMOTE  = 10'h060;
    localparam logic [9:0] CODE_MINOR   = 10'h062;
    localparam logic [9:0] CODE_ALM     = 10'h063;

    // selectable internal functions
    typedef enum logic [3:0] {
        FN_NONE, FN_RUN, FN_READY, FN_START_CMD_RUNNING_OUT, FN_ENERGY, FN_NET,
        FN_DCFEED, FN_LIFE, FN_PWROFF, FN_SAVTOG, FN_AVGCUR,
        FN_SECONDARY_FAULT_OUT, FN_MAINT, FN_REMOTE, FN_MINOR, FN_ALM
    } fn_e;

    // source conditions from the drive core
    typedef struct packed {
        logic       ready;
        logic       freq_ok;
        logic       stopped;
        logic       dc_brake;
        logic       start_cmd;
        logic       output_shutoff_in;
        logic       fault;
        logic       fault_internal;
        logic       drive_reset;
        logic       supply_off;
        logic       power_fail;
        logic       undervolt;
        logic       fan_fail;
        logic       comm_warn;
        logic [3:0] life_near;
        logic       net_binary;
        logic       saving_upd;
        logic       avg_pulse;
        logic [3:0] fault_code;
    } status_s;

endpackage

/* core/output_terminal_function_select.sv */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module output_terminal_function_select #(
    parameter int N_TERM      = 7,
    parameter int RELAY_FIRST = 5,
    parameter int E_W         = 16,
    parameter int M_W         = 16
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    output logic [31:0]                  rdata,
    input  wire term_sel_pkg::status_s   status,
    input  wire logic [E_W-1:0]          energy_in,
    input  wire logic [M_W-1:0]          maint_count,
    output logic [N_TERM-1:0]            term_q
);

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    // override needs terminals 1..4; relays at the top end
    if (N_TERM < 5 || N_TERM > 8 || RELAY_FIRST < 5 ||
        RELAY_FIRST > N_TERM || E_W > 31 || M_W > 32) begin : g_chk
        $error("unsupported terminal or width parameters");
    end

    // --------------------------------------------------------------
    // register file
    // --------------------------------------------------------------
    localparam int CW = term_sel_pkg::CODE_W;

    logic [CW-1:0]     code_q [N_TERM];
    logic              fcmode_q;
    logic [N_TERM-1:0] remote_q;
    logic [E_W-1:0]    estep_q;
    logic [M_W-1:0]    mthr_q;

    // true for codes that are pulse trains unfit for relays
    function automatic logic fast_code(input logic [CW-1:0] c);
        logic [CW-1:0] b;
        b = (c >= term_sel_pkg::CODE_NEG_OFS) ?
            CW'(c - term_sel_pkg::CODE_NEG_OFS) : c;
        return (b == term_sel_pkg::CODE_SAVTOG) ||
               (b == term_sel_pkg::CODE_AVGCUR);
    endfunction

    // per-terminal code registers; relays refuse pulse codes
    for (genvar i = 0; i < N_TERM; i++) begin : g_code
        localparam logic [7:0] OFS = 8'(term_sel_pkg::OFS_CODE0 + 4 * i);
        localparam logic [CW-1:0] RV =
            (i == 0) ? term_sel_pkg::RST_CODE_RUN :
            (i == term_sel_pkg::RST_TERM_ALM) ?
            term_sel_pkg::RST_CODE_ALM : term_sel_pkg::RST_CODE_OFF;
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                code_q[i] <= RV;
            end else if (ce && wr_stb && addr == OFS) begin
                // refused write leaves the old code in place
                if (!(i >= RELAY_FIRST && fast_code(wdata[CW-1:0]))) begin
                    code_q[i] <= wdata[CW-1:0];
                end
            end
        end
    end

    // control registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fcmode_q <= term_sel_pkg::RST_FCMODE;
            remote_q <= '0;
            estep_q  <= '0;
            mthr_q   <= '0;
        end else if (ce && wr_stb) begin
            unique case (addr)
                term_sel_pkg::OFS_FCMODE: fcmode_q <= wdata[term_sel_pkg::FCMODE_POS];
                term_sel_pkg::OFS_REMOTE: remote_q <= wdata[N_TERM-1:0];
                term_sel_pkg::OFS_ESTEP:  estep_q  <= wdata[E_W-1:0];
                term_sel_pkg::OFS_MTHR:   mthr_q   <= wdata[M_W-1:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] rd_d;
    always_comb begin
        rd_d = '0;
        for (int i = 0; i < N_TERM; i++) begin
            if (addr == 8'(term_sel_pkg::OFS_CODE0 + 4 * i)) begin
                rd_d = 32'(code_q[i]);
            end
        end
        unique case (addr)
            term_sel_pkg::OFS_FCMODE: rd_d = 32'(fcmode_q);
            term_sel_pkg::OFS_REMOTE: rd_d = 32'(remote_q);
            term_sel_pkg::OFS_ESTEP:  rd_d = 32'(estep_q);
            term_sel_pkg::OFS_MTHR:   rd_d = 32'(mthr_q);
            term_sel_pkg::OFS_STATUS: rd_d = 32'(term_q);
            default: ;
        endcase
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= rd_stb ? rd_d : '0;
        end
    end

    // --------------------------------------------------------------
    // pulse and toggle sources
    // --------------------------------------------------------------
    logic [E_W:0] eacc_q;
    logic         epulse_q;
    logic [E_W:0] esum;

    assign esum = eacc_q + (E_W+1)'(energy_in);

    // a zero step disables the pulse rather than spinning
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eacc_q   <= '0;
            epulse_q <= 1'b0;
        end else if (ce) begin
            if (estep_q != '0 && esum >= (E_W+1)'(estep_q)) begin
                eacc_q   <= esum - (E_W+1)'(estep_q);
                epulse_q <= 1'b1;
            end else begin
                eacc_q   <= (estep_q == '0) ? '0 : esum;
                epulse_q <= 1'b0;
            end
        end
    end

    // level flips once per saving-average update
    logic tog_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_q <= 1'b0;
        end else if (ce && status.saving_upd) begin
            tog_q <= ~tog_q;
        end
    end

    // secondary fault: held by reset, dropped at supply off
    logic secondary_fault_out_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_fault_out_q <= 1'b0;
        end else if (ce) begin
            if (status.supply_off) begin
                secondary_fault_out_q <= 1'b0;
            end else begin
                secondary_fault_out_q <= status.fault | (secondary_fault_out_q & status.drive_reset);
            end
        end
    end

    // --------------------------------------------------------------
    // function levels
    // --------------------------------------------------------------
    logic [15:0] fn_act;
    logic        pf_uv;
    logic        run_sig;

    assign pf_uv   = status.power_fail | status.undervolt;
    assign run_sig = status.freq_ok & ~status.stopped & ~status.dc_brake &
                     ~status.output_shutoff_in;

    // all functions but remote evaluated once, shared by every terminal
    always_comb begin
        fn_act = '0;
        fn_act[term_sel_pkg::FN_RUN]    = run_sig;
        fn_act[term_sel_pkg::FN_READY]  = (status.ready | run_sig) & ~pf_uv;
        fn_act[term_sel_pkg::FN_START_CMD_RUNNING_OUT]   = status.start_cmd;
        fn_act[term_sel_pkg::FN_ENERGY] = epulse_q;
        fn_act[term_sel_pkg::FN_NET]    = status.net_binary;
        fn_act[term_sel_pkg::FN_DCFEED] = pf_uv;
        fn_act[term_sel_pkg::FN_LIFE]   = |status.life_near;
        fn_act[term_sel_pkg::FN_PWROFF] = status.fault & status.fault_internal;
        fn_act[term_sel_pkg::FN_SAVTOG] = tog_q;
        fn_act[term_sel_pkg::FN_AVGCUR] = status.avg_pulse;
        fn_act[term_sel_pkg::FN_SECONDARY_FAULT_OUT]   = secondary_fault_out_q;
        fn_act[term_sel_pkg::FN_MAINT]  = maint_count >= mthr_q;
        fn_act[term_sel_pkg::FN_MINOR]  = status.fan_fail | status.comm_warn;
        fn_act[term_sel_pkg::FN_ALM]    = status.fault;
    end

    // map a base code to its function
    function automatic term_sel_pkg::fn_e code_fn(input logic [CW-1:0] b);
        unique case (b)
            term_sel_pkg::CODE_RUN:    return term_sel_pkg::FN_RUN;
            term_sel_pkg::CODE_READY:  return term_sel_pkg::FN_READY;
            term_sel_pkg::CODE_START_CMD_RUNNING_OUT:   return term_sel_pkg::FN_START_CMD_RUNNING_OUT;
            term_sel_pkg::CODE_ENERGY: return term_sel_pkg::FN_ENERGY;
            term_sel_pkg::CODE_NET:    return term_sel_pkg::FN_NET;
            term_sel_pkg::CODE_DCFEED: return term_sel_pkg::FN_DCFEED;
            term_sel_pkg::CODE_LIFE:   return term_sel_pkg::FN_LIFE;
            term_sel_pkg::CODE_PWROFF: return term_sel_pkg::FN_PWROFF;
            term_sel_pkg::CODE_SAVTOG: return term_sel_pkg::FN_SAVTOG;
            term_sel_pkg::CODE_AVGCUR: return term_sel_pkg::FN_AVGCUR;
            term_sel_pkg::CODE_SECONDARY_FAULT_OUT:   return term_sel_pkg::FN_SECONDARY_FAULT_OUT;
            term_sel_pkg::CODE_MAINT:  return term_sel_pkg::FN_MAINT;
            term_sel_pkg::CODE_REMOTE: return term_sel_pkg::FN_REMOTE;
            term_sel_pkg::CODE_MINOR:  return term_sel_pkg::FN_MINOR;
            term_sel_pkg::CODE_ALM:    return term_sel_pkg::FN_ALM;
            default:                   return term_sel_pkg::FN_NONE;
        endcase
    endfunction

    // --------------------------------------------------------------
    // per-terminal selection, polarity and override
    // --------------------------------------------------------------
    logic [N_TERM-1:0] lvl;
    logic [N_TERM-1:0] inv;
    logic              fc_on;

    assign fc_on = fcmode_q & status.fault;

    for (genvar i = 0; i < N_TERM; i++) begin : g_term
        logic [CW-1:0]     base;
        term_sel_pkg::fn_e fn;
        logic              act;
        // unknown codes and 999 never conduct outside the fault-code override on terminals 1..4
        assign inv[i] = code_q[i] >= term_sel_pkg::CODE_NEG_OFS &&
                        code_q[i] <= term_sel_pkg::CODE_NEG_END;
        assign base = inv[i] ?
                      CW'(code_q[i] - term_sel_pkg::CODE_NEG_OFS) : code_q[i];
        assign fn   = (code_q[i] > term_sel_pkg::CODE_NEG_END) ?
                      term_sel_pkg::FN_NONE : code_fn(base);
        // same source may feed any number of terminals
        assign act  = (fn == term_sel_pkg::FN_REMOTE) ? remote_q[i] :
                      fn_act[fn];
        // none selected stays off in either polarity
        assign lvl[i] = (fn == term_sel_pkg::FN_NONE) ? 1'b0 :
                        act ^ inv[i];

        // registered so a code change cannot glitch the pin
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                term_q[i] <= 1'b0;
            end else if (ce) begin
                if (fc_on && i >= 1 && i <= 4) begin
                    term_q[i] <= status.fault_code[(i+3)%4];
                end else begin
                    term_q[i] <= lvl[i];
                end
            end
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    relay_code_check_a: assert property (
        ce && wr_stb && addr == 8'(term_sel_pkg::OFS_CODE0 + 4 * (N_TERM - 1)) &&
        fast_code(wdata[CW-1:0]) |=> $stable(code_q[N_TERM-1]))
        else $error("relay took a pulse code");

    secondary_fault_out_hold_reset_a: assert property (
        ce && secondary_fault_out_q && status.drive_reset && !status.supply_off |=> secondary_fault_out_q)
        else $error("secondary fault dropped during reset");

    secondary_fault_out_supply_off_a: assert property (
        ce && status.supply_off |=> !secondary_fault_out_q)
        else $error("secondary fault held after supply off");

    toggle_flip_a: assert property (
        ce && status.saving_upd |=> tog_q != $past(tog_q))
        else $error("saving toggle did not flip");

    // residue stays below one step while each input is below a step
    energy_residue_a: assert property (
        ce && estep_q != '0 && eacc_q < (E_W+1)'(estep_q) && energy_in < estep_q
        |=> eacc_q < (E_W+1)'($past(estep_q)))
        else $error("energy accumulator overran step");

    ready_pf_off_a: assert property (
        pf_uv |-> !fn_act[term_sel_pkg::FN_READY])
        else $error("ready on during power failure");

    start_cmd_running_out_start_a: assert property (
        status.start_cmd |-> fn_act[term_sel_pkg::FN_START_CMD_RUNNING_OUT])
        else $error("start running output off with start on");

    fcode_override_a: assert property (
        ce && fc_on |=> term_q[4:1] == $past(status.fault_code))
        else $error("fault code not on terminals");

    run_term_keep_a: assert property (
        ce |=> term_q[0] == $past(lvl[0]) && term_q[N_TERM-1] == $past(lvl[N_TERM-1]))
        else $error("run or relay terminal overridden");

    run_dc_off_a: assert property (
        status.dc_brake || status.stopped |-> !fn_act[term_sel_pkg::FN_RUN])
        else $error("running output on while stopped");

    // pin-level checks on the transistor terminals, override excluded
    polarity_pair_a: assert property (
        ce && !fc_on && code_q[1] < term_sel_pkg::CODE_NEG_OFS &&
        code_q[2] == code_q[1] + term_sel_pkg::CODE_NEG_OFS &&
        code_fn(code_q[1]) != term_sel_pkg::FN_NONE &&
        code_fn(code_q[1]) != term_sel_pkg::FN_REMOTE |=> term_q[1] != term_q[2])
        else $error("inverted twin terminal matched");

    // remote bits are per terminal, so only shared sources compare
    twin_terminal_a: assert property (
        ce && !fc_on && code_q[1] == code_q[3] &&
        code_q[1] != term_sel_pkg::CODE_REMOTE &&
        code_q[1] != term_sel_pkg::CODE_REMOTE + term_sel_pkg::CODE_NEG_OFS
        |=> term_q[1] == term_q[3])
        else $error("shared function differs on twin terminals");

    alm_term_a: assert property (
        ce && !fc_on && code_q[2] == term_sel_pkg::CODE_ALM
        |=> term_q[2] == $past(status.fault))
        else $error("fault terminal not following fault");

    maint_term_a: assert property (
        ce && !fc_on && code_q[1] == term_sel_pkg::CODE_MAINT
        |=> term_q[1] == ($past(maint_count) >= $past(mthr_q)))
        else $error("maintenance terminal wrong");

    minor_term_a: assert property (
        ce && !fc_on && code_q[1] == term_sel_pkg::CODE_MINOR
        |=> term_q[1] == ($past(status.fan_fail) || $past(status.comm_warn)))
        else $error("minor alarm terminal wrong");

    dc_feed_term_a: assert property (
        ce && !fc_on && code_q[1] == term_sel_pkg::CODE_DCFEED
        |=> term_q[1] == ($past(status.power_fail) || $past(status.undervolt)))
        else $error("dc feed terminal wrong");

    life_term_a: assert property (
        ce && !fc_on && code_q[1] == term_sel_pkg::CODE_LIFE
        |=> term_q[1] == |$past(status.life_near))
        else $error("life alarm terminal wrong");

    pwroff_term_a: assert property (
        ce && !fc_on && code_q[1] == term_sel_pkg::CODE_PWROFF
        |=> term_q[1] == ($past(status.fault) && $past(status.fault_internal)))
        else $error("power-off fault terminal wrong");

    cov_fault_override_c: cover property (ce && fc_on ##1 ce && !fc_on);
    cov_secondary_fault_out_cycle_c: cover property (status.fault ##1 status.drive_reset [*2] ##1 !secondary_fault_out_q);
    cov_energy_pulse_c: cover property (epulse_q ##1 !epulse_q);
    cov_saving_toggle_c: cover property (ce && status.saving_upd ##1 tog_q);

endmodule

/* testbench/term_watch.sv */
`timescale 1ns/10ps
// ----------------------------------------
// far side: equipment watching one terminal
// ----------------------------------------
module term_watch #(
    parameter int N_TERM = 7,
    parameter int WATCH  = 4
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [N_TERM-1:0] term_q,
    output logic [15:0]            rise_cnt_q
);
    logic prev_q;

    // a counter only sees edges, so a stuck level never counts twice
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q     <= 1'b0;
            rise_cnt_q <= 16'h0000;
        end else begin
            prev_q <= term_q[WATCH];
            if (term_q[WATCH] && !prev_q) begin
                rise_cnt_q <= rise_cnt_q + 16'h0001;
            end
        end
    end
endmodule

/* testbench/test_output_terminal_function_select.sv */
`timescale 1ns/10ps
module test_output_terminal_function_select;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] mask;
    } note_s;
    logic                  ref_clk, rst_n, ce, wr_stb, rd_stb, rd_d, cnt_req;
    logic [7:0]            addr;
    logic [31:0]           wdata, rdata, got;
    term_sel_pkg::status_s status;
    logic [15:0]           energy_in, maint_count, rise_cnt_q, base, mc;
    logic [6:0]            term_q;
    note_s                 notes[$];
    note_s                 nt;
    int                    fails, checks, seed, sum, i, j;
    // ----------------------------------------
    // function table: code, asserted conditions, expected level
    // ----------------------------------------
    logic [9:0]  tc[21] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h00B, 10'h00B, 10'h00B,
        10'h00B, 10'h02D, 10'h02D, 10'h052, 10'h055, 10'h055, 10'h05A, 10'h05B, 10'h05B,
        10'h062, 10'h062, 10'h063, 10'h060, 10'h055};
    logic [15:0] tf[21] = '{16'h0001, 16'h0003, 16'h0005, 16'h0009, 16'h0010, 16'h0001,
        16'h0030, 16'h0050, 16'h0180, 16'h0088, 16'h0200, 16'h0020, 16'h0040, 16'h0400,
        16'h0100, 16'h0900, 16'h1000, 16'h2000, 16'h0100, 16'h0000, 16'h0000};
    logic [20:0] te = 21'b0_1111_1011_1111_0011_0001;

    output_terminal_function_select dut_u (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .addr       (addr),
        .wdata      (wdata),
        .wr_stb     (wr_stb),
        .rd_stb     (rd_stb),
        .rdata      (rdata),
        .status     (status),
        .energy_in  (energy_in),
        .maint_count(maint_count),
        .term_q     (term_q)
    );
    term_watch watch_u (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .term_q    (term_q),
        .rise_cnt_q(rise_cnt_q)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{v, m});
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic idle(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    // two idle edges let the new status reach the terminals first
    task automatic term_chk(input logic [6:0] v, input logic [6:0] m);
        idle(2);
        bus_rd(8'h2C, {25'h0, v}, {25'h0, m});
    endtask
    task automatic cnt_chk(input logic [15:0] v);
        notes.push_back('{{16'h0, v}, 32'h0000_FFFF});
        cnt_req <= 1'b1;
        @(posedge ref_clk);
        cnt_req <= 1'b0;
    endtask
    function automatic term_sel_pkg::status_s mk(input logic [15:0] f);
        mk = '0;
        {mk.comm_warn, mk.fan_fail, mk.fault_internal, mk.life_near[3]} = f[13:10];
        {mk.net_binary, mk.fault, mk.start_cmd, mk.undervolt, mk.power_fail} = f[9:5];
        {mk.ready, mk.output_shutoff_in, mk.dc_brake, mk.stopped, mk.freq_ok} = f[4:0];
    endfunction
    // same code on terminals 1 and 3, inverted code on terminal 2
    task automatic tri_chk(input logic [9:0] c, input term_sel_pkg::status_s s, input logic e);
        logic r;
        r = s.freq_ok & ~s.stopped & ~s.dc_brake & ~s.output_shutoff_in;
        bus_wr(8'h04, {22'h0, c});
        bus_wr(8'h08, {22'h0, c + 10'h064});
        bus_wr(8'h0C, {22'h0, c});
        status <= s;
        term_chk({1'b0, s.fault, 1'b0, e, ~e, e, r}, 7'h7F);
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // result monitor: oldest note against what appears
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (rd_d || cnt_req) begin
            got = rd_d ? rdata : {16'h0, rise_cnt_q};
            nt = notes.pop_front();
            checks++;
            if ((got & nt.mask) !== nt.val) begin
                fails++;
                $display("wrong value at %0t: got %h expected %h", $time, got & nt.mask, nt.val);
            end
        end
        rd_d <= rd_stb;
    end

    initial begin
        #2_000_000;
        fails++;
        end_of_test();
    end

    initial begin
        {rst_n, wr_stb, rd_stb, cnt_req, addr, wdata} = '0;
        {status, energy_in, maint_count} = '0;
        ce = 1'b1;
        seed = 32'hb0657837;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset contents, back to back reads, one unmapped place
        for (i = 0; i < 7; i++) begin
            bus_rd(8'(4 * i), (i == 0) ? 0 : (i == 5) ? 32'h63 : 32'h3E7, 32'h0000_03FF);
        end
        for (i = 7; i < 12; i++) begin
            bus_rd(8'(4 * i), 32'h0000_0000, 32'h0000_FFFF);
        end
        bus_rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        bus_wr(8'h20, 32'h0000_000E);
        for (i = 0; i < 21; i++) begin
            tri_chk(tc[i], mk(tf[i]), te[i]);
        end
        // maintenance threshold at its boundary, then random counts
        bus_wr(8'h28, 32'h0000_0010);
        for (i = 0; i < 8; i++) begin
            mc = (i == 0) ? 16'h0010 : (i == 1) ? 16'h000F : 16'($random(seed)) & 16'h001F;
            maint_count <= mc;
            tri_chk(10'h05F, '0, mc >= 16'h0010);
        end
        // pulse output kept on a transistor terminal, never a relay
        bus_wr(8'h10, 32'h0000_004F);
        bus_wr(8'h24, 32'h0000_0064);
        idle(3);
        base = rise_cnt_q;
        energy_in <= 16'h0019;
        repeat (40) @(posedge ref_clk);
        energy_in <= 16'h0000;
        idle(5);
        cnt_chk(base + 16'd10);
        idle(1);
        base = rise_cnt_q;
        sum = 0;
        for (i = 0; i < 50; i++) begin
            mc = 16'($random(seed)) & 16'h001F; // small steps keep pulses apart
            sum += mc;
            energy_in <= mc;
            @(posedge ref_clk);
        end
        energy_in <= 16'h0000;
        idle(5);
        cnt_chk(base + 16'(sum / 100));
        // toggle output, and codes a relay must refuse
        bus_wr(8'h04, 32'h0000_005C);
        for (j = 1; j < 5; j++) begin
            status <= '{saving_upd: 1'b1, default: '0};
            idle(1);
            status <= '0;
            term_chk({5'h0, 1'(j % 2), 1'b0}, 7'h02);
        end
        bus_wr(8'h14, 32'h0000_005C);
        bus_wr(8'h18, 32'h0000_00C1);
        bus_wr(8'h10, 32'h0000_00C1);
        bus_rd(8'h14, 32'h0000_0063, 32'h0000_03FF);
        bus_rd(8'h18, 32'h0000_03E7, 32'h0000_03FF);
        bus_rd(8'h10, 32'h0000_00C1, 32'h0000_03FF);
        status <= '{avg_pulse: 1'b1, default: '0};
        term_chk(7'h00, 7'h10);
        // secondary fault through drive reset and supply off
        bus_wr(8'h04, 32'h0000_005E);
        bus_wr(8'h08, 32'h0000_0063);
        for (j = 0; j < 5; j++) begin
            status <= '{fault: (j == 0 || j > 2), drive_reset: (j == 1),
                        supply_off: (j == 4), default: '0};
            term_chk({4'h0, (j == 0 || j > 2), (j < 2 || j == 3), 1'b0}, 7'h06);
        end
        // a write strobe with the enable low is ignored
        idle(1);
        ce <= 1'b0;
        bus_wr(8'h1C, 32'h0000_0001);
        ce <= 1'b1;
        bus_rd(8'h1C, 32'h0000_0000, 32'h0000_0001);
        bus_wr(8'h1C, 32'h0000_0001);
        for (i = 1; i < 5; i++) begin
            bus_wr(8'(4 * i), 32'h0000_0062);
        end
        status <= '{fault: 1'b1, freq_ok: 1'b1, fault_code: 4'hA, default: '0};
        term_chk(7'h35, 7'h7F);
        status <= '{freq_ok: 1'b1, fault_code: 4'hA, default: '0};
        term_chk(7'h01, 7'h7F);
        bus_wr(8'h1C, 32'h0000_0000);
        status <= '{fault: 1'b1, freq_ok: 1'b1, fault_code: 4'hA, default: '0};
        term_chk(7'h21, 7'h7F);
        idle(4);
        end_of_test();
    end
endmodule
